// ---- logic/hsrt_pkg.sv ----
/*
 * hsrt_pkg: constants and carrier types for the high-speed repeater test-mode
 * forwarding block.
 * assumes: a 125 MHz core clock; port-side phy logic decodes line states and
 * delivers high-speed packets as bytes on that same clock.
 */
package hsrt_pkg;

    localparam int unsigned HSRT_CLK_MHZ = 125;
    // single-ended zero must persist this long before falling back
    localparam int unsigned HSRT_SE0_TIME_US = 3000;
    localparam int unsigned HSRT_SE0_CYCLES = HSRT_SE0_TIME_US * HSRT_CLK_MHZ;
    localparam int HSRT_SE0_CNT_W = 20;
    localparam int HSRT_DATA_W = 8;

    localparam logic HSRT_DIR_IN2OUT = 1'h0;
    localparam logic HSRT_DIR_OUT2IN = 1'h1;

    typedef enum logic [2:0]
    {
        HSRT_PASS = 3'h1,
        HSRT_HS = 3'h2,
        HSRT_FORCE = 3'h4
    } hsrt_mode_t;

    // one high-speed packet byte
    typedef struct packed
    {
        logic valid;
        logic last;
        logic [HSRT_DATA_W-1:0] data;
    } hsrt_pkt_t;

    // decoded line condition of one port
    typedef struct packed
    {
        logic se0;
        logic test_j;
        logic test_k;
    } hsrt_line_t;

    // continuous forced level on one port
    typedef struct packed
    {
        logic force_j;
        logic force_k;
    } hsrt_drive_t;

    typedef struct packed
    {
        hsrt_mode_t mode;
        logic en_meta;
        logic en_sync;
        logic busy;
        logic dir;
        logic [HSRT_SE0_CNT_W-1:0] se0_cnt;
        hsrt_pkt_t inner_tx;
        hsrt_pkt_t outer_tx;
        hsrt_drive_t drv_inner;
        hsrt_drive_t drv_outer;
        logic hs_ind;
        logic switch_on;
        logic sync_on;
    } hsrt_state_t;

    localparam hsrt_state_t HSRT_STATE_RST = '{mode: HSRT_PASS, switch_on: 1'h1, default: '0};

endpackage

// ---- logic/hsrt_repeater.sv ----
/*
 * hsrt_repeater: mode control, packet retiming and forced J/K output of a
 * two-port high-speed repeater (inner port toward the host, outer_port away).
 * assumes: rx packets, line states and bus condition flags come from phy logic
 * on clk; enable is a board pin and is synchronised here; the analog switch
 * and line drivers obey switch_on, sync_on and the drive outputs.
 */
// Operation
// - in high-speed, retime each packet and resend it on the opposite port, both ways.
// - test J or K seen on one port forces that level continuously on the other.
// - forced level holds until enable or chip reset goes to zero.
// - status output is high exactly while in high-speed state with synchroniser on.
// - enter high-speed on completed connection; leave on suspend or full/low speed.
// - forwarding latency kept minimal because of the 192 bit-time response limit.
// - no host, device or hub function and no identifier registers; forwarding only.
// - single-ended zero for 3 ms in high-speed stops synchroniser, closes switch, falls back.
`timescale 1ns/1ps
`default_nettype none

module hsrt_repeater
    import hsrt_pkg::*;
#(
    parameter logic [HSRT_SE0_CNT_W-1:0] SE0_CYCLES_P = HSRT_SE0_CNT_W'(HSRT_SE0_CYCLES)
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic enable,
    input wire logic hs_connected,
    input wire logic bus_suspend,
    input wire logic bus_fsls,
    input wire hsrt_pkt_t inner_rx,
    input wire hsrt_pkt_t outer_rx,
    input wire hsrt_line_t inner_line,
    input wire hsrt_line_t outer_line,
    output hsrt_pkt_t inner_tx,
    output hsrt_pkt_t outer_tx,
    output hsrt_drive_t inner_drive,
    output hsrt_drive_t outer_drive,
    output logic switch_on,
    output logic sync_on,
    output logic hs_state_indicator
);

    hsrt_state_t q;
    hsrt_state_t d;
    logic take_in;
    logic take_out;
    logic idle_se0;

    // a packet already in flight keeps its direction; inner wins a tie
    assign take_in = inner_rx.valid && !(q.busy && q.dir == HSRT_DIR_OUT2IN);
    assign take_out = outer_rx.valid && !take_in && !(q.busy && q.dir == HSRT_DIR_IN2OUT);
    assign idle_se0 = (inner_line.se0 || outer_line.se0) && !inner_rx.valid && !outer_rx.valid;

    always_comb
    begin
        d = q;
        d.en_meta = enable;
        d.en_sync = q.en_meta;
        // tx bytes last one cycle; nothing is forwarded outside high-speed
        d.inner_tx = '0;
        d.outer_tx = '0;
        case (q.mode)
            HSRT_PASS:
            begin
                d.busy = 1'h0;
                d.se0_cnt = '0;
                // a flagged suspend or full/low speed keeps it out, else the states would alternate
                if (q.en_sync && hs_connected && !bus_suspend && !bus_fsls)
                begin
                    d.mode = HSRT_HS;
                end
            end
            HSRT_HS:
            begin
                // single register stage each way: the least a retimer can add
                if (take_in)
                begin
                    d.outer_tx = inner_rx;
                    d.busy = !inner_rx.last;
                    d.dir = HSRT_DIR_IN2OUT;
                end
                else if (take_out)
                begin
                    d.inner_tx = outer_rx;
                    d.busy = !outer_rx.last;
                    d.dir = HSRT_DIR_OUT2IN;
                end
                if (idle_se0)
                begin
                    d.se0_cnt = q.se0_cnt + 1'h1;
                end
                else
                begin
                    d.se0_cnt = '0;
                end
                // exits first, then se0 timeout, then test J/K with the inner port first
                if (!q.en_sync || bus_suspend || bus_fsls)
                begin
                    d.mode = HSRT_PASS;
                end
                else if (idle_se0 && q.se0_cnt == SE0_CYCLES_P - 1'h1)
                begin
                    d.mode = HSRT_PASS;
                end
                else if (inner_line.test_j || inner_line.test_k)
                begin
                    d.mode = HSRT_FORCE;
                    d.drv_outer.force_j = inner_line.test_j;
                    d.drv_outer.force_k = !inner_line.test_j;
                end
                else if (outer_line.test_j || outer_line.test_k)
                begin
                    d.mode = HSRT_FORCE;
                    d.drv_inner.force_j = outer_line.test_j;
                    d.drv_inner.force_k = !outer_line.test_j;
                end
            end
            HSRT_FORCE:
            begin
                // only enable low (or reset) ends it; bus activity is ignored
                if (!q.en_sync)
                begin
                    d.mode = HSRT_PASS;
                end
            end
            default:
            begin
                d = HSRT_STATE_RST;
            end
        endcase
        if (d.mode != HSRT_FORCE)
        begin
            d.drv_inner = '0;
            d.drv_outer = '0;
        end
        if (d.mode != HSRT_HS)
        begin
            d.busy = 1'h0;
        end
        d.hs_ind = (d.mode == HSRT_HS);
        d.switch_on = (d.mode == HSRT_PASS);
        d.sync_on = (d.mode != HSRT_PASS);
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            q <= HSRT_STATE_RST;
        end
        else
        begin
            q <= d;
        end
    end

    // pure forwarder: no descriptor or identifier storage exists here
    assign inner_tx = q.inner_tx;
    assign outer_tx = q.outer_tx;
    assign inner_drive = q.drv_inner;
    assign outer_drive = q.drv_outer;
    assign switch_on = q.switch_on;
    assign sync_on = q.sync_on;
    assign hs_state_indicator = q.hs_ind;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // properties sample registered state; enable adds two synchroniser cycles
    fwd_in_out_a: assert property ((q.mode == HSRT_HS && take_in) |=>
        (outer_tx.valid && outer_tx.data == $past(inner_rx.data) && !inner_tx.valid))
        else $error("inner packet byte not resent on outer port next cycle");
    fwd_out_in_a: assert property ((q.mode == HSRT_HS && take_out) |=>
        (inner_tx.valid && inner_tx.data == $past(outer_rx.data) && !outer_tx.valid))
        else $error("outer packet byte not resent on inner port next cycle");
    force_enter_a: assert property ((q.mode == HSRT_HS && q.en_sync && !bus_suspend && !bus_fsls
        && !idle_se0 && inner_line.test_k && !inner_line.test_j) |=> (outer_drive.force_k && !outer_drive.force_j))
        else $error("test K on inner port did not force K on outer port");
    force_hold_a: assert property ((q.mode == HSRT_FORCE && q.en_sync) |=>
        ($stable(outer_drive) && $stable(inner_drive) && q.mode == HSRT_FORCE))
        else $error("forced level changed while enabled");
    force_exit_a: assert property ((q.mode == HSRT_FORCE && !enable)[*3] |->
        ##1 (inner_drive == '0 && outer_drive == '0 && switch_on))
        else $error("forced level not released after enable went low");
    status_rise_a: assert property ($rose(hs_state_indicator) |->
        ($past(q.en_sync) && $past(hs_connected) && sync_on && !switch_on))
        else $error("status rose without a completed high-speed connection");
    hs_leave_a: assert property ((q.mode == HSRT_HS && (bus_suspend || bus_fsls)) |=>
        (!hs_state_indicator && switch_on && !sync_on))
        else $error("high-speed state kept through suspend or full/low speed");
    se0_fall_a: assert property ((q.mode == HSRT_HS && idle_se0 && q.en_sync && !bus_suspend && !bus_fsls
        && q.se0_cnt == SE0_CYCLES_P - 1'h1) |=> (switch_on && !sync_on && q.mode == HSRT_PASS))
        else $error("single-ended zero timeout did not fall back to pass-through");
    mode_onehot_a: assert property ($onehot(q.mode) && (switch_on != sync_on))
        else $error("mode not one-hot or switch and synchroniser both on");
    hs_block_a: assert property ((q.mode == HSRT_PASS && (bus_suspend || bus_fsls)) |=>
        (!hs_state_indicator && switch_on))
        else $error("high-speed state entered during suspend or full/low speed");
    force_j_a: assert property ((q.mode == HSRT_HS && q.en_sync && !bus_suspend && !bus_fsls && !idle_se0
        && !inner_line.test_j && !inner_line.test_k && outer_line.test_j)
        |=> (inner_drive.force_j && !inner_drive.force_k && outer_drive == '0))
        else $error("test J on outer port did not force J on inner port");
    force_status_a: assert property ((q.mode == HSRT_FORCE) |->
        (!hs_state_indicator && sync_on && !switch_on))
        else $error("status high or synchroniser off in forced state");
    drop_idle_a: assert property ((q.mode != HSRT_HS) |=> (!inner_tx.valid && !outer_tx.valid))
        else $error("byte forwarded outside high-speed state");

    hs_entry_c: cover property (q.mode == HSRT_PASS ##1 q.mode == HSRT_HS);
    packet_c: cover property (take_in && inner_rx.last ##[1:20] take_out && outer_rx.last);
    force_c: cover property (q.mode == HSRT_FORCE ##[1:20] q.mode == HSRT_PASS);
    se0_c: cover property (q.mode == HSRT_HS && q.se0_cnt == SE0_CYCLES_P - 1'h1);
    fsls_exit_c: cover property (q.mode == HSRT_HS && bus_fsls ##1 q.mode == HSRT_PASS);

endmodule

`default_nettype wire

// ---- tb/hsrt_far_end.sv ----
/*
 * hsrt_far_end: host and device stand-in driving both repeater ports.
 * assumes: bench clock; the bench pops exp_q when a tx byte shows.
 */
`timescale 1ns/1ps
`default_nettype none

module hsrt_far_end
    import hsrt_pkg::*;
(
    input wire logic clk,
    output hsrt_pkt_t inner_rx,
    output hsrt_pkt_t outer_rx,
    output hsrt_line_t inner_line,
    output hsrt_line_t outer_line
);
    logic [31:0] cnt = '0;
    logic [63:0] exp_q[$];

    initial
    begin
        inner_rx = '{valid: 1'h0, last: 1'h0, data: 8'h5a};
        outer_rx = '{valid: 1'h0, last: 1'h0, data: 8'ha5};
        inner_line = '0;
        outer_line = '0;
    end

    always @(posedge clk)
        cnt <= cnt + 32'h1;

    // fwd low: bytes the repeater must drop
    task automatic send(input logic port, input int n, input bit fwd);
        hsrt_pkt_t p;
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk);
            p = '{valid: 1'h1, last: (i == n - 1), data: 8'($urandom)};
            if (port)
                outer_rx <= p;
            else
                inner_rx <= p;
            if (fwd)
                exp_q.push_back({cnt + 32'h2, 22'h0, port, p.last, p.data});
        end
        @(posedge clk);
        p.valid = 1'h0;
        // released bus shows the inverse, never a stale byte
        p.data = ~p.data;
        if (port)
            outer_rx <= p;
        else
            inner_rx <= p;
    endtask

    task automatic set_line(input logic port, input hsrt_line_t l);
        @(posedge clk);
        if (port)
            outer_line <= l;
        else
            inner_line <= l;
    endtask
endmodule

`default_nettype wire

// ---- tb/test_hs_repeater_test_mode_forwarding.sv ----
/*
 * test_hs_repeater_test_mode_forwarding: self-checking bench for hsrt_repeater.
 * assumes: hsrt_far_end models both ports; se0 timeout shortened to 16.
 */
`timescale 1ns/1ps
`default_nettype none

module test_hs_repeater_test_mode_forwarding
    import hsrt_pkg::*;
;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic enable = 1'h0;
    logic hs_connected = 1'h0;
    logic bus_suspend = 1'h0;
    logic bus_fsls = 1'h0;
    hsrt_pkt_t inner_rx, outer_rx, inner_tx, outer_tx, pk;
    hsrt_line_t inner_line, outer_line;
    hsrt_drive_t inner_drive, outer_drive;
    logic switch_on, sync_on, hs_state_indicator;
    logic [63:0] eb;
    int error_cnt = 0;
    int checks = 0;

    always #4 clk = ~clk;

    hsrt_repeater #(.SE0_CYCLES_P(20'h10)) DUT (.clk(clk), .nrst(nrst), .enable(enable),
        .hs_connected(hs_connected), .bus_suspend(bus_suspend), .bus_fsls(bus_fsls),
        .inner_rx(inner_rx), .outer_rx(outer_rx), .inner_line(inner_line), .outer_line(outer_line),
        .inner_tx(inner_tx), .outer_tx(outer_tx), .inner_drive(inner_drive),
        .outer_drive(outer_drive), .switch_on(switch_on), .sync_on(sync_on),
        .hs_state_indicator(hs_state_indicator));

    hsrt_far_end far (.clk(clk), .inner_rx(inner_rx), .outer_rx(outer_rx),
        .inner_line(inner_line), .outer_line(outer_line));

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
        checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // m: 0 pass-through, 1 high-speed, 2 outer forced k, 3 inner forced j
    task automatic check_mode(input int m);
        logic [6:0] e;
        e = {m == 0, m != 0, m == 1, m == 3, 1'h0, 1'h0, m == 2};
        chk("mode", 64'(e), 64'({switch_on, sync_on, hs_state_indicator, inner_drive, outer_drive}));
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // every tx byte must match the oldest sent byte, exactly one cycle on
    always @(negedge clk)
        if (inner_tx.valid === 1'h1 || outer_tx.valid === 1'h1)
        begin
            pk = outer_tx.valid ? outer_tx : inner_tx;
            eb = far.exp_q.size() != 0 ? far.exp_q.pop_front() : '1;
            chk("tx_byte", eb, {far.cnt, 22'h0, ~outer_tx.valid, pk.last, pk.data});
        end

    always @(posedge clk)
        if (far.cnt == 32'hbb8)
        begin
            error_cnt++;
            give_verdict();
        end

    initial
    begin
        void'($urandom(80));
        repeat (4) @(posedge clk);
        nrst <= 1'h1;
        wait_cyc(0);
        check_mode(0);
        @(posedge clk);
        enable <= 1'h1;
        hs_connected <= 1'h1;
        wait_cyc(6);
        check_mode(1);
        for (int i = 0; i < 6; i++)
            far.send(i[0], 1 + $urandom % 8, 1'b1);
        wait_cyc(3);
        $display("test forwarding done");
        @(posedge clk);
        bus_suspend <= 1'h1;
        wait_cyc(3);
        check_mode(0);
        far.send(1'b0, 3, 1'b0);
        bus_suspend <= 1'h0;
        wait_cyc(4);
        check_mode(1);
        @(posedge clk);
        bus_fsls <= 1'h1;
        wait_cyc(3);
        check_mode(0);
        @(posedge clk);
        bus_fsls <= 1'h0;
        wait_cyc(4);
        check_mode(1);
        $display("test suspend done");
        far.set_line(1'b0, 3'h1);
        wait_cyc(3);
        check_mode(2);
        far.set_line(1'b0, 3'h0);
        bus_fsls <= 1'h1;
        far.send(1'b1, 3, 1'b0);
        wait_cyc(4);
        check_mode(2);
        @(posedge clk);
        enable <= 1'h0;
        wait_cyc(5);
        check_mode(0);
        @(posedge clk);
        bus_fsls <= 1'h0;
        enable <= 1'h1;
        wait_cyc(6);
        check_mode(1);
        far.set_line(1'b1, 3'h2);
        wait_cyc(3);
        check_mode(3);
        @(posedge clk);
        nrst <= 1'h0;
        wait_cyc(0);
        check_mode(0);
        far.set_line(1'b1, 3'h0);
        nrst <= 1'h1;
        wait_cyc(6);
        check_mode(1);
        $display("test forced level done");
        @(posedge clk);
        hs_connected <= 1'h0;
        far.set_line(1'b0, 3'h4);
        wait_cyc(8);
        check_mode(1);
        wait_cyc(16);
        check_mode(0);
        chk("bytes_left", 64'h0, 64'(far.exp_q.size()));
        $display("test se0 timeout done");
        give_verdict();
    end
endmodule

`default_nettype wire
